// ---- src/bbx_exec.sv ----
// execution unit for add, and, bit set, bit clear and bit test skip
module bbx_exec (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [bbx_pkg::INSTR_W-1:0] instr,
  input  wire logic [bbx_pkg::PORT_W-1:0]  port_pins,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [bbx_pkg::APB_AW-1:0]  paddr,
  input  wire logic [bbx_pkg::APB_DW-1:0]  pwdata,
  output logic      [bbx_pkg::APB_DW-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic      [bbx_pkg::PC_W-1:0]    fetch_addr,
  output logic                             instr_take,
  output logic                             slot_discard,
  output logic                             prescaler_clr,
  output logic                             op_foreign,
  output logic      [bbx_pkg::PORT_W-1:0]  port_out,
  output logic      [bbx_pkg::PORT_W-1:0]  port_oe_n
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    bbx_pkg::bbx_phase_e               phase;
    logic [bbx_pkg::INSTR_W-1:0]       ir;
    logic                              taken;
    logic                              live;
    logic                              flush;
    logic                              hold;
    logic [bbx_pkg::DATA_W-1:0]        opnd;
    logic [bbx_pkg::DATA_W-1:0]        acc;
    logic [bbx_pkg::DATA_W-1:0]        status;
    logic [bbx_pkg::DATA_W-1:0]        timer;
    logic [bbx_pkg::PC_W-1:0]          pc;
    logic [bbx_pkg::PORT_W-1:0]        port_lat;
    logic [bbx_pkg::PORT_W-1:0]        dir;
    logic [bbx_pkg::PORT_W-1:0]        s1;
    logic [bbx_pkg::PORT_W-1:0]        s2;
    logic [bbx_pkg::PORT_W-1:0]        s3;
    logic [bbx_pkg::PORT_W-1:0]        pins;
    logic                              run;
    logic                              psc_tmr;
    logic                              pready;
    logic                              pslverr;
    logic [bbx_pkg::APB_DW-1:0]        prdata;
    logic                              take;
    logic                              discard;
    logic                              psc_clr;
    logic                              foreign;
  } bbx_state_s;

  bbx_state_s st_r;
  bbx_state_s st_nxt;

  logic [bbx_pkg::FADDR_W-1:0] fa;
  logic                        dbit;
  logic [bbx_pkg::BSEL_W-1:0]  bsel;
  logic [bbx_pkg::DATA_W-1:0]  lit;
  logic                        op_add;
  logic                        op_andf;
  logic                        op_bcf;
  logic                        op_bsf;
  logic                        op_btc;
  logic                        op_bts;
  logic                        op_andl;
  logic                        op_dir;
  logic                        is_foreign;
  logic [bbx_pkg::DATA_W-1:0]  bmask;
  logic [bbx_pkg::DATA_W:0]    sum9;
  logic [bbx_pkg::NIB_W:0]     nib;
  logic [bbx_pkg::DATA_W-1:0]  res;
  logic                        bit_val;
  logic                        skip_take;
  logic                        acc_we;
  logic                        file_we;
  logic                        set_z;
  logic [bbx_pkg::PC_W-1:0]    pc_inc;
  logic [bbx_pkg::DATA_W-1:0]  pins_ext;
  logic [bbx_pkg::DATA_W-1:0]  file_rd;
  logic [bbx_pkg::DATA_W-1:0]  mem_rdata;
  logic                        mem_we;
  logic [bbx_pkg::FADDR_W-1:0] mem_raddr;
  logic                        apb_hit;
  logic [bbx_pkg::APB_DW-1:0]  apb_rd;
  logic                        apb_wr;

  // ------------------------------------------------------------------
  // decode of the held instruction
  // ------------------------------------------------------------------
  assign fa   = st_r.ir[bbx_pkg::FADDR_W-1:0];
  assign dbit = st_r.ir[bbx_pkg::IR_D_BIT];
  assign bsel = st_r.ir[bbx_pkg::IR_B_LO +: bbx_pkg::BSEL_W];
  assign lit  = st_r.ir[bbx_pkg::DATA_W-1:0];
  assign op_add  = st_r.ir[bbx_pkg::IR_OP6_LO +: 6] == bbx_pkg::OP6_ADD;
  assign op_andf = st_r.ir[bbx_pkg::IR_OP6_LO +: 6] == bbx_pkg::OP6_ANDF;
  assign op_bcf  = st_r.ir[bbx_pkg::IR_OP4_LO +: 4] == bbx_pkg::OP4_BCF;
  assign op_bsf  = st_r.ir[bbx_pkg::IR_OP4_LO +: 4] == bbx_pkg::OP4_BSF;
  assign op_btc  = st_r.ir[bbx_pkg::IR_OP4_LO +: 4] == bbx_pkg::OP4_BTC;
  assign op_bts  = st_r.ir[bbx_pkg::IR_OP4_LO +: 4] == bbx_pkg::OP4_BTS;
  assign op_andl = st_r.ir[bbx_pkg::IR_OP4_LO +: 4] == bbx_pkg::OP4_ANDL;
  assign op_dir  = st_r.ir == bbx_pkg::OP_DIR_PORT2;
  // anything else belongs to the neighbouring execution units
  assign is_foreign = ~(op_add | op_andf | op_bcf | op_bsf | op_btc
                        | op_bts | op_andl | op_dir);

  // ------------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------------
  assign bmask  = bbx_pkg::BIT_ONE << bsel;
  assign sum9   = {1'b0, st_r.acc} + {1'b0, st_r.opnd};
  assign nib    = {1'b0, st_r.acc[bbx_pkg::NIB_W-1:0]}
                + {1'b0, st_r.opnd[bbx_pkg::NIB_W-1:0]};
  assign res = op_add  ? sum9[bbx_pkg::DATA_W-1:0] :
               op_andf ? (st_r.acc & st_r.opnd) :
               op_andl ? (st_r.acc & lit) :
               op_bcf  ? (st_r.opnd & ~bmask) :
               op_bsf  ? (st_r.opnd | bmask) :
                         st_r.opnd;
  assign bit_val   = st_r.opnd[bsel];
  assign skip_take = (op_btc & ~bit_val) | (op_bts & bit_val);
  assign acc_we  = op_andl | ((op_add | op_andf) & ~dbit);
  assign file_we = ((op_add | op_andf) & dbit) | op_bcf | op_bsf;
  assign set_z   = op_add | op_andf | op_andl;
  assign pc_inc  = st_r.pc + bbx_pkg::PC_ONE;

  // operand source; the port always reads the filtered pins
  assign pins_ext = {{(bbx_pkg::DATA_W-bbx_pkg::PORT_W){1'b0}}, st_r.pins};
  assign file_rd = (fa == bbx_pkg::F_TIMER)  ? st_r.timer :
                   (fa == bbx_pkg::F_PCL)    ? pc_inc[bbx_pkg::DATA_W-1:0] :
                   (fa == bbx_pkg::F_STATUS) ? st_r.status :
                   (fa == bbx_pkg::F_PORT2)  ? pins_ext :
                                               mem_rdata;

  // general registers live outside; write lands at the commit edge
  assign mem_we = (st_r.phase == bbx_pkg::PH_COMMIT) & st_r.run & st_r.live
                  & file_we & (fa != bbx_pkg::F_TIMER) & (fa != bbx_pkg::F_PCL)
                  & (fa != bbx_pkg::F_STATUS) & (fa != bbx_pkg::F_PORT2);
  assign mem_raddr = (st_r.phase == bbx_pkg::PH_SAMPLE)
                     ? instr[bbx_pkg::FADDR_W-1:0] : fa;

  bbx_regfile u_regfile (
    .clk   (clk),
    .rst   (rst),
    .we    (mem_we),
    .waddr (fa),
    .wdata (res),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  assign apb_hit = (paddr == bbx_pkg::A_CTRL) | (paddr == bbx_pkg::A_ACC)
                 | (paddr == bbx_pkg::A_STATUS) | (paddr == bbx_pkg::A_PC)
                 | (paddr == bbx_pkg::A_TIMER) | (paddr == bbx_pkg::A_PORT)
                 | (paddr == bbx_pkg::A_DIR) | (paddr == bbx_pkg::A_PINS);
  assign apb_rd =
    (paddr == bbx_pkg::A_CTRL)   ? {30'h0, st_r.psc_tmr, st_r.run} :
    (paddr == bbx_pkg::A_ACC)    ? {24'h0, st_r.acc} :
    (paddr == bbx_pkg::A_STATUS) ? {24'h0, st_r.status} :
    (paddr == bbx_pkg::A_PC)     ? {21'h0, st_r.pc} :
    (paddr == bbx_pkg::A_TIMER)  ? {24'h0, st_r.timer} :
    (paddr == bbx_pkg::A_PORT)   ? {26'h0, st_r.port_lat} :
    (paddr == bbx_pkg::A_DIR)    ? {26'h0, st_r.dir} :
    (paddr == bbx_pkg::A_PINS)   ? {26'h0, st_r.pins} : 32'h0;
  // write takes effect only at the access edge that samples pready
  assign apb_wr = psel & penable & st_r.pready & pwrite & apb_hit;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.take    = 1'b0;
    st_nxt.discard = 1'b0;
    st_nxt.psc_clr = 1'b0;
    st_nxt.foreign = 1'b0;
    // three stage pin synchroniser, a bit moves once stages two and three agree
    st_nxt.s1   = port_pins;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.pins = (st_r.s2 & st_r.s3) | (st_r.pins & (st_r.s2 ^ st_r.s3));
    // four phases make one instruction cycle
    case (st_r.phase)
      bbx_pkg::PH_SAMPLE: begin
        st_nxt.phase = bbx_pkg::PH_OPERAND;
        st_nxt.taken = st_r.run;
        st_nxt.live  = st_r.run & ~st_r.flush;
        if (st_r.run) begin
          st_nxt.ir   = instr;
          st_nxt.take = 1'b1;
        end
      end
      bbx_pkg::PH_OPERAND: begin
        st_nxt.phase = bbx_pkg::PH_EXEC;
        st_nxt.opnd  = file_rd;
      end
      bbx_pkg::PH_EXEC: begin
        st_nxt.phase = bbx_pkg::PH_COMMIT;
      end
      bbx_pkg::PH_COMMIT: begin
        st_nxt.phase = bbx_pkg::PH_SAMPLE;
        st_nxt.taken = 1'b0; // a slot cut by a stop must not commit on resume
        if (st_r.taken && st_r.run) begin
          st_nxt.flush = 1'b0;
          st_nxt.hold  = 1'b0;
          if (!st_r.live) begin
            // nop slot; after a pc load the new address is fetched again
            if (!st_r.hold) begin
              st_nxt.pc = pc_inc;
            end
          end else begin
            st_nxt.pc      = pc_inc;
            st_nxt.foreign = is_foreign;
            if (acc_we) begin
              st_nxt.acc = res;
            end
            if (file_we) begin
              case (fa)
                bbx_pkg::F_TIMER: begin
                  st_nxt.timer   = res;
                  st_nxt.psc_clr = st_r.psc_tmr;
                end
                bbx_pkg::F_PCL: begin
                  st_nxt.pc = {st_r.status[bbx_pkg::ST_PAGE_HI:
                                           bbx_pkg::ST_PAGE_LO],
                               1'b0, res};
                  st_nxt.flush   = 1'b1;
                  st_nxt.hold    = 1'b1;
                  st_nxt.discard = 1'b1;
                end
                bbx_pkg::F_STATUS: begin
                  st_nxt.status = res;
                end
                bbx_pkg::F_PORT2: begin
                  st_nxt.port_lat = res[bbx_pkg::PORT_W-1:0];
                end
                default: begin
                  st_nxt.port_lat = st_nxt.port_lat;
                end
              endcase
            end
            // flags applied after the write so they win over a status target
            if (set_z) begin
              st_nxt.status[bbx_pkg::ST_Z] = (res == bbx_pkg::ZERO8);
            end
            if (op_add) begin
              st_nxt.status[bbx_pkg::ST_C]  = sum9[bbx_pkg::DATA_W];
              st_nxt.status[bbx_pkg::ST_DC] = nib[bbx_pkg::NIB_W];
            end
            if (op_dir) begin
              st_nxt.dir = st_r.acc[bbx_pkg::PORT_W-1:0];
            end
            if (skip_take) begin
              st_nxt.flush   = 1'b1;
              st_nxt.discard = 1'b1;
            end
          end
        end
      end
      default: begin
        st_nxt.phase = bbx_pkg::PH_SAMPLE;
      end
    endcase
    // apb slave: zero wait states, read data caught in the setup cycle
    st_nxt.pready = psel & ~penable;
    if (psel && !penable) begin
      st_nxt.prdata  = apb_rd;
      st_nxt.pslverr = ~apb_hit;
    end
    // software writes land last and so win over execution in that cycle
    if (apb_wr) begin
      case (paddr)
        bbx_pkg::A_CTRL: begin
          st_nxt.run     = pwdata[bbx_pkg::CTRL_RUN];
          st_nxt.psc_tmr = pwdata[bbx_pkg::CTRL_PSC];
        end
        bbx_pkg::A_ACC:    st_nxt.acc = pwdata[bbx_pkg::DATA_W-1:0];
        bbx_pkg::A_STATUS: st_nxt.status = pwdata[bbx_pkg::DATA_W-1:0];
        bbx_pkg::A_PC:     st_nxt.pc = pwdata[bbx_pkg::PC_W-1:0];
        bbx_pkg::A_TIMER:  st_nxt.timer = pwdata[bbx_pkg::DATA_W-1:0];
        bbx_pkg::A_PORT:   st_nxt.port_lat = pwdata[bbx_pkg::PORT_W-1:0];
        bbx_pkg::A_DIR:    st_nxt.dir = pwdata[bbx_pkg::PORT_W-1:0];
        default: begin
          st_nxt.run = st_nxt.run; // pins register is read only
        end
      endcase
    end
  end

  // register the state; reset loads constants only
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r     <= '0;
      st_r.pc  <= bbx_pkg::RST_PC;
      st_r.dir <= bbx_pkg::RST_DIR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs, each a flip-flop of the state
  // ------------------------------------------------------------------
  assign prdata        = st_r.prdata;
  assign pready        = st_r.pready;
  assign pslverr       = st_r.pslverr;
  assign fetch_addr    = st_r.pc;
  assign instr_take    = st_r.take;
  assign slot_discard  = st_r.discard;
  assign prescaler_clr = st_r.psc_clr;
  assign op_foreign    = st_r.foreign;
  assign port_out      = st_r.port_lat;
  assign port_oe_n     = st_r.dir;

endmodule : bbx_exec

// ---- src/bbx_pkg.sv ----
// shared constants and types for the byte and bit alu execution block
package bbx_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int DATA_W  = 8;
  localparam int INSTR_W = 12;
  localparam int PC_W    = 11;
  localparam int FADDR_W = 5;
  localparam int BSEL_W  = 3;
  localparam int PORT_W  = 6;
  localparam int APB_AW  = 8;
  localparam int APB_DW  = 32;
  localparam int NIB_W   = 4;
  localparam int FILE_DEPTH = 32;

  // ------------------------------------------------------------------
  // instruction cycle phases, one per oscillator period (four in all)
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_SAMPLE,
    PH_OPERAND,
    PH_EXEC,
    PH_COMMIT
  } bbx_phase_e;

  // ------------------------------------------------------------------
  // instruction fields and opcodes
  // ------------------------------------------------------------------
  localparam int IR_D_BIT   = 5;
  localparam int IR_B_LO    = 5;
  localparam int IR_OP6_LO  = 6;
  localparam int IR_OP4_LO  = 8;
  localparam logic [5:0] OP6_ADD  = 6'h07;
  localparam logic [5:0] OP6_ANDF = 6'h05;
  localparam logic [3:0] OP4_BCF  = 4'h4;
  localparam logic [3:0] OP4_BSF  = 4'h5;
  localparam logic [3:0] OP4_BTC  = 4'h6;
  localparam logic [3:0] OP4_BTS  = 4'h7;
  localparam logic [3:0] OP4_ANDL = 4'he;
  localparam logic [INSTR_W-1:0] OP_DIR_PORT2 = 12'h006;

  // ------------------------------------------------------------------
  // file addresses held outside the general register file
  // ------------------------------------------------------------------
  localparam logic [FADDR_W-1:0] F_TIMER  = 5'h01;
  localparam logic [FADDR_W-1:0] F_PCL    = 5'h02;
  localparam logic [FADDR_W-1:0] F_STATUS = 5'h03;
  localparam logic [FADDR_W-1:0] F_PORT2  = 5'h06;

  // ------------------------------------------------------------------
  // status bit positions and program counter layout
  // ------------------------------------------------------------------
  localparam int ST_C       = 0;
  localparam int ST_DC      = 1;
  localparam int ST_Z       = 2;
  localparam int ST_PAGE_LO = 5;
  localparam int ST_PAGE_HI = 6;
  localparam logic [PC_W-1:0]   PC_ONE  = 11'h001;
  localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO8   = 8'h00;

  // ------------------------------------------------------------------
  // apb register map (byte addresses) and control bits
  // ------------------------------------------------------------------
  localparam logic [APB_AW-1:0] A_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] A_ACC    = 8'h04;
  localparam logic [APB_AW-1:0] A_STATUS = 8'h08;
  localparam logic [APB_AW-1:0] A_PC     = 8'h0c;
  localparam logic [APB_AW-1:0] A_TIMER  = 8'h10;
  localparam logic [APB_AW-1:0] A_PORT   = 8'h14;
  localparam logic [APB_AW-1:0] A_DIR    = 8'h18;
  localparam logic [APB_AW-1:0] A_PINS   = 8'h1c;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PSC = 1;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [PC_W-1:0]   RST_PC  = 11'h000;
  localparam logic [PORT_W-1:0] RST_DIR = 6'h3f;

endpackage : bbx_pkg

// ---- src/bbx_regfile.sv ----
// general purpose file registers with a registered read port
module bbx_regfile (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        we,
  input  wire logic [bbx_pkg::FADDR_W-1:0] waddr,
  input  wire logic [bbx_pkg::DATA_W-1:0]  wdata,
  input  wire logic [bbx_pkg::FADDR_W-1:0] raddr,
  output logic      [bbx_pkg::DATA_W-1:0]  rdata
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [bbx_pkg::FILE_DEPTH-1:0][bbx_pkg::DATA_W-1:0] mem;
    logic [bbx_pkg::DATA_W-1:0]                          rd;
  } bbx_rf_s;

  bbx_rf_s rf_r;
  bbx_rf_s rf_nxt;

  // read sees the old word on a same-cycle write; caller never needs both
  always_comb begin
    rf_nxt = rf_r;
    rf_nxt.rd = rf_r.mem[raddr];
    if (we) begin
      rf_nxt.mem[waddr] = wdata;
    end
  end

  // register the whole copy
  always_ff @(posedge clk) begin
    if (rst) begin
      rf_r <= '0;
    end else begin
      rf_r <= rf_nxt;
    end
  end

  assign rdata = rf_r.rd;

endmodule : bbx_regfile

// ---- verif/bbx_exec_sva.sv ----
// port checker for the byte and bit execution unit
module bbx_exec_sva (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [bbx_pkg::APB_AW-1:0]  paddr,
  input wire logic [bbx_pkg::APB_DW-1:0]  prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [bbx_pkg::PC_W-1:0]    fetch_addr,
  input wire logic                        instr_take,
  input wire logic                        slot_discard,
  input wire logic                        prescaler_clr,
  input wire logic                        op_foreign
);
  // ------------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------------
  logic [bbx_pkg::PC_W-1:0] pc_prev_r;
  logic                     pc_apb_r;
  // software pc writes may set any bit, so they are told apart here
  always_ff @(posedge clk) begin
    pc_prev_r <= fetch_addr;
    pc_apb_r  <= psel && penable && pwrite && (paddr == bbx_pkg::A_PC);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_pready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (psel && !penable &&
    paddr > bbx_pkg::A_PINS |=> pslverr && pready)
    else $error("unmapped access not refused");
  a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_take_spacing: assert property (instr_take |=> !instr_take [*3])
    else $error("instruction slots closer than four clocks");
  a_discard_cause: assert property (slot_discard |-> $past(instr_take, 3))
    else $error("discard not tied to a committed slot");
  a_foreign_cause: assert property (op_foreign |-> $past(instr_take, 3))
    else $error("foreign pulse not tied to a slot");
  a_psc_cause: assert property (prescaler_clr |-> $past(instr_take, 3))
    else $error("prescaler clear outside a commit");
  a_pc_page_bit: assert property (fetch_addr != pc_prev_r && !pc_apb_r &&
    fetch_addr != pc_prev_r + bbx_pkg::PC_ONE |-> !fetch_addr[8])
    else $error("pc bit eight set by a pc write");
endmodule : bbx_exec_sva
bind bbx_exec bbx_exec_sva i_sva (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fetch_addr(fetch_addr),
  .instr_take(instr_take), .slot_discard(slot_discard),
  .prescaler_clr(prescaler_clr), .op_foreign(op_foreign));

// ---- verif/bbx_exec_bench.sv ----
// self-checking bench for the byte and bit execution unit
module bbx_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        instr_take, slot_discard, prescaler_clr, op_foreign;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [10:0] fetch_addr, last_pc;
  logic [5:0]  port_pins, port_out, port_oe_n;
  logic [11:0] rom [2048];
  int          n_mismatch, num_checks, n_disc, n_psc, d0, n_frn, f0;
  bbx_exec i_dut (.clk(clk), .rst(rst), .instr(rom[fetch_addr]),
    .port_pins(port_pins), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_addr(fetch_addr), .instr_take(instr_take),
    .slot_discard(slot_discard), .prescaler_clr(prescaler_clr),
    .op_foreign(op_foreign), .port_out(port_out), .port_oe_n(port_oe_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pulse counters; pc seen at a discard tells where a jump landed
  always @(posedge clk) begin
    if (slot_discard === 1'b1) begin
      n_disc++;
      last_pc = fetch_addr;
    end
    if (prescaler_clr === 1'b1) n_psc++;
    if (op_foreign === 1'b1) n_frn++;
  end
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait limit here; the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // runs rom from zero for n slots; trailing nops absorb a late stop
  task automatic go(input int n, input logic [31:0] ctl,
                    input logic [7:0] acc);
    int k;
    apb(1'b1, bbx_pkg::A_PC, 32'h0);
    apb(1'b1, bbx_pkg::A_ACC, {24'h0, acc});
    apb(1'b1, bbx_pkg::A_CTRL, ctl);
    k = 0;
    while (k < n) begin
      @(posedge clk);
      if (instr_take === 1'b1) k++;
    end
    apb(1'b1, bbx_pkg::A_CTRL, 32'h0);
    repeat (8) @(posedge clk);
    for (k = 0; k < 8; k++) rom[k] = 12'h000;
  endtask : go
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, bbx_pkg::A_DIR, 32'h0);
    check(q, 32'h3f);
    apb(1'b0, 8'h20, 32'h0);
    check(q, 32'h0);
    check(32'(e), 32'h1);
  endtask : t_regs
  task automatic t_add;
    rom[0] = 12'h1e8;
    rom[1] = 12'h1c8;
    go(2, 32'h1, 8'h9c);
    apb(1'b0, bbx_pkg::A_ACC, 32'h0);
    check(q, 32'h38);
    apb(1'b0, bbx_pkg::A_STATUS, 32'h0);
    check(q & 32'h7, 32'h3);
  endtask : t_add
  task automatic t_and_bits;
    rom[0] = 12'he07;
    go(1, 32'h1, 8'h38);
    apb(1'b0, bbx_pkg::A_ACC, 32'h0);
    check(q, 32'h0);
    rom[0] = 12'h508;
    rom[1] = 12'h4e8;
    go(2, 32'h1, 8'hff);
    apb(1'b0, bbx_pkg::A_STATUS, 32'h0);
    check(q & 32'h7, 32'h7);
    rom[0] = 12'h148;
    go(1, 32'h1, 8'hff);
    apb(1'b0, bbx_pkg::A_ACC, 32'h0);
    check(q, 32'h1d);
  endtask : t_and_bits
  task automatic t_skip;
    rom[0] = 12'h628;
    rom[1] = 12'he00;
    rom[2] = 12'h728;
    rom[3] = 12'he0f;
    rom[4] = 12'h708;
    rom[5] = 12'he00;
    d0 = n_disc;
    go(6, 32'h1, 8'hff);
    apb(1'b0, bbx_pkg::A_ACC, 32'h0);
    check(q, 32'h0f);
    check(n_disc - d0, 2);
  endtask : t_skip
  task automatic t_port;
    apb(1'b1, bbx_pkg::A_PORT, 32'h3f);
    rom[0] = 12'h006;
    rom[1] = 12'h406;
    go(2, 32'h1, 8'h2a);
    check(32'(port_oe_n), 32'h2a);
    check(32'(port_out), 32'h14);
  endtask : t_port
  task automatic t_psc;
    d0 = n_psc;
    rom[0] = 12'h501;
    go(1, 32'h3, 8'h00);
    check(n_psc - d0, 1);
    rom[0] = 12'h501;
    f0 = n_frn;
    go(2, 32'h1, 8'h00);
    check(n_psc - d0, 1);
    check(n_frn - f0, 1); // trailing nop belongs to another unit
  endtask : t_psc
  task automatic t_pc;
    apb(1'b1, bbx_pkg::A_STATUS, 32'h60);
    d0 = n_disc;
    rom[0] = 12'h1e2;
    go(1, 32'h1, 8'h10);
    check(32'(last_pc), 32'h611);
    check(n_disc - d0, 1);
  endtask : t_pc
  // watchdog sized well past the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict;
  end
  initial begin
    rst       = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    port_pins = 6'h15;
    foreach (rom[i]) rom[i] = 12'h000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_add;
    t_and_bits;
    t_skip;
    t_port;
    t_psc;
    t_pc;
    give_verdict;
  end
endmodule : bbx_exec_bench
